/* src/nvac_top.sv */
// Indirect access controller for the data memory and the program flash
`timescale 1ns/100ps
// Contract
// - Memories reached only through six registers: control, unlock, data and address bytes.
// - Data memory uses low data byte for value, low address byte for location.
// - Flash read joins data bytes to 14-bit word, address bytes to 13 bits.
// - Flash holds 4K or 8K words depending on variant parameter.
// - Flash is read one word at a time; no write or erase path.
// - Data memory byte writes erase the location first, then store.
// - Write duration is set by an internal timer.
// - Code protection blocks programmer access but never the core.
// - Space select picks data when clear, flash when set; reset clears it.
// - Read and write strobes only set by software, cleared by hardware at completion.
// - Write permit gates data writes and is clear after power-up.
// - External or watchdog reset during write sets the abort flag.
// - Reset clears the data and address registers.
// - Write completion sets the done flag; software clears it.
// - Unlock port stores nothing and reads as zero.
// - Low data byte is 8-bit read/write, reset zero.
// - Write starts only after 55h then AAh to unlock, then write strobe.
// - Data memory read byte appears next cycle and holds until replaced.
// - Write strobe refused without permit; clearing permit later does not stop write.
// - Write strobe ignored while space select points at flash.
module nvac_top
  import nvac_pkg::*;
#(
  parameter int PF_WORDS     = NV_PF_WORDS_8K,
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_rst_power_on,
  input  wire logic                    i_rst_external,
  input  wire logic                    i_rst_watchdog,
  input  wire logic [2:0]              i_sfr_idx,
  input  wire logic                    i_sfr_wr,
  input  wire logic                    i_sfr_rd,
  input  wire logic [NV_DATA_W-1:0]    i_sfr_wdata,
  output logic      [NV_DATA_W-1:0]    o_sfr_rdata,
  input  wire logic                    i_done_flag_clear,
  output logic                         o_write_done_flag,
  output logic      [NV_PF_ADDR_W-1:0] o_pf_addr,
  input  wire logic [NV_PF_WORD_W-1:0] i_pf_word,
  input  wire logic                    i_code_protect,
  input  wire logic                    i_pgm_rd,
  input  wire logic                    i_pgm_space,
  input  wire logic [NV_PF_ADDR_W-1:0] i_pgm_addr,
  output logic      [NV_PF_WORD_W-1:0] o_pgm_data,
  output logic                         o_pgm_valid,
  output logic                         o_pgm_denied
);

  localparam int CNT_W = (WRITE_CYCLES > 1) ? $clog2(WRITE_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  // Variant size as a word-address mask
  localparam logic [NV_PF_ADDR_W-1:0] PF_MASK = NV_PF_ADDR_W'(PF_WORDS - 1);

  // ==========================================================
  // Registers
  logic                    space_reg;
  logic                    abort_reg;
  logic                    permit_reg;
  logic                    wstrobe_reg;
  logic                    rstrobe_reg;
  logic [NV_DATA_W-1:0]    data_lo_reg;
  logic [NV_DATA_HI_W-1:0] data_hi_reg;
  logic [NV_DATA_W-1:0]    addr_lo_reg;
  logic [NV_ADDR_HI_W-1:0] addr_hi_reg;
  nvac_unlock_e            unlock_reg;
  nvac_unlock_e            unlock_next;
  nvac_write_e             write_reg;
  logic [CNT_W-1:0]        count_reg;
  logic [NV_DATA_W-1:0]    lat_addr_reg;
  logic [NV_DATA_W-1:0]    lat_data_reg;
  logic                    pgm_pend_reg;
  logic                    pgm_space_reg;
  logic [NV_DATA_W-1:0]    pgm_ee_addr_reg;
  logic [NV_DATA_W-1:0]    ee_rd_core;
  logic [NV_DATA_W-1:0]    ee_rd_pgm;

  // ==========================================================
  // Decoding
  // Six register selects
  wire wr_ctl     = i_sfr_wr && (i_sfr_idx == NV_IDX_CONTROL);
  wire wr_unlock  = i_sfr_wr && (i_sfr_idx == NV_IDX_UNLOCK);
  wire wr_data_lo = i_sfr_wr && (i_sfr_idx == NV_IDX_DATA_LOW);
  wire wr_data_hi = i_sfr_wr && (i_sfr_idx == NV_IDX_DATA_HIGH);
  wire wr_addr_lo = i_sfr_wr && (i_sfr_idx == NV_IDX_ADDR_LOW);
  wire wr_addr_hi = i_sfr_wr && (i_sfr_idx == NV_IDX_ADDR_HIGH);

  wire new_space = i_sfr_wdata[NV_BIT_SPACE];
  wire busy      = (write_reg == WR_BUSY);

  // Write needs the armed unlock state; permit already set
  // Ignored when the control write points at flash
  wire wr_start = wr_ctl && i_sfr_wdata[NV_BIT_WSTROBE] && (unlock_reg == UNL_ARMED)
                  && permit_reg && !new_space && !busy;
  wire wr_finish = busy && (count_reg == CNT_ZERO);

  // Software can only set the read strobe
  wire rd_set     = wr_ctl && i_sfr_wdata[NV_BIT_RSTROBE];
  wire core_pf_rd = rd_set && new_space;

  wire [NV_PF_ADDR_W-1:0] core_pf_addr = {addr_hi_reg, addr_lo_reg} & PF_MASK;

  // Programmer refused while protected; core flash read has priority
  wire pgm_take = i_pgm_rd && !i_code_protect && !(i_pgm_space && core_pf_rd);

  // Erase at start, store at finish, one write port
  wire                 ee_wr_en   = wr_start || wr_finish;
  wire [NV_DATA_W-1:0] ee_wr_addr = wr_start ? addr_lo_reg : lat_addr_reg;
  wire [NV_DATA_W-1:0] ee_wr_data = wr_start ? NV_ERASED_BYTE : lat_data_reg;

  wire [NV_DATA_W-1:0] ctl_view = {space_reg, 3'h0, abort_reg, permit_reg,
                                   wstrobe_reg, rstrobe_reg};

  // Unlock port reads zero; unmapped indices too
  wire [NV_DATA_W-1:0] rd_mux =
      (i_sfr_idx == NV_IDX_CONTROL)   ? ctl_view :
      (i_sfr_idx == NV_IDX_DATA_LOW)  ? data_lo_reg :
      (i_sfr_idx == NV_IDX_DATA_HIGH) ? {2'h0, data_hi_reg} :
      (i_sfr_idx == NV_IDX_ADDR_LOW)  ? addr_lo_reg :
      (i_sfr_idx == NV_IDX_ADDR_HIGH) ? {3'h0, addr_hi_reg} : NV_ZERO_BYTE;

  // ==========================================================
  // Unlock sequence
  // Any other register write breaks the sequence
  always_comb begin
    unlock_next = unlock_reg;
    if (wr_unlock) begin
      case (unlock_reg)
        UNL_GOT_FIRST: begin
          if (i_sfr_wdata == NV_UNLOCK_SECOND) begin
            unlock_next = UNL_ARMED;
          end else if (i_sfr_wdata == NV_UNLOCK_FIRST) begin
            unlock_next = UNL_GOT_FIRST;
          end else begin
            unlock_next = UNL_IDLE;
          end
        end
        default: begin
          unlock_next = (i_sfr_wdata == NV_UNLOCK_FIRST) ? UNL_GOT_FIRST : UNL_IDLE;
        end
      endcase
    end else if (i_sfr_wr) begin
      unlock_next = UNL_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      unlock_reg <= UNL_IDLE;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      // Reset clears space select; permit clear
      space_reg   <= 1'b0;
      permit_reg  <= 1'b0;
      wstrobe_reg <= 1'b0;
      rstrobe_reg <= 1'b0;
      // Abort flag set by the external or watchdog reset that cut a write
      if (busy && (i_rst_external || i_rst_watchdog)) begin
        abort_reg <= 1'b1;
      end else if (i_rst_power_on) begin
        abort_reg <= 1'b0;
      end
    end else begin
      if (wr_ctl) begin
        space_reg  <= new_space;
        permit_reg <= i_sfr_wdata[NV_BIT_PERMIT];
        abort_reg  <= i_sfr_wdata[NV_BIT_ABORT];
      end
      if (wr_start) begin
        wstrobe_reg <= 1'b1;
      end else if (wr_finish) begin
        wstrobe_reg <= 1'b0;
      end
      rstrobe_reg <= rd_set;
    end
  end

  // ==========================================================
  // Data and address registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      data_lo_reg <= '0;
      data_hi_reg <= '0;
      addr_lo_reg <= '0;
      addr_hi_reg <= '0;
    end else begin
      if (rstrobe_reg && space_reg) begin
        // Flash word split over both data bytes
        data_lo_reg <= i_pf_word[NV_DATA_W-1:0];
        data_hi_reg <= i_pf_word[NV_PF_WORD_W-1:NV_DATA_W];
      end else if (rstrobe_reg) begin
        // Byte loaded the cycle after the strobe
        data_lo_reg <= ee_rd_core;
      end else begin
        if (wr_data_lo) begin
          data_lo_reg <= i_sfr_wdata;
        end
        if (wr_data_hi) begin
          data_hi_reg <= i_sfr_wdata[NV_DATA_HI_W-1:0];
        end
      end
      // Flash high part lives in the high address byte
      if (wr_addr_lo) begin
        addr_lo_reg <= i_sfr_wdata;
      end
      if (wr_addr_hi) begin
        addr_hi_reg <= i_sfr_wdata[NV_ADDR_HI_W-1:0];
      end
    end
  end

  // ==========================================================
  // Timed write cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      write_reg    <= WR_IDLE;
      count_reg    <= CNT_ZERO;
      lat_addr_reg <= '0;
      lat_data_reg <= '0;
    end else if (wr_start) begin
      write_reg    <= WR_BUSY;
      count_reg    <= CNT_LOAD;
      // Later register writes cannot touch the stored byte
      lat_addr_reg <= addr_lo_reg;
      lat_data_reg <= data_lo_reg;
    end else if (wr_finish) begin
      write_reg <= WR_IDLE;
    end else if (busy) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // Set on completion; the set beats a same-cycle clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_write_done_flag <= 1'b0;
    end else begin
      o_write_done_flag <= wr_finish || (o_write_done_flag && !i_done_flag_clear);
    end
  end

  // ==========================================================
  // Flash address and programmer port
  // Flash is only ever addressed for single-word reads
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pf_addr <= '0;
    end else if (core_pf_rd) begin
      o_pf_addr <= core_pf_addr;
    end else if (pgm_take && i_pgm_space) begin
      o_pf_addr <= i_pgm_addr & PF_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pgm_pend_reg    <= 1'b0;
      pgm_space_reg   <= 1'b0;
      pgm_ee_addr_reg <= '0;
      o_pgm_data      <= '0;
      o_pgm_valid     <= 1'b0;
      o_pgm_denied    <= 1'b0;
    end else begin
      pgm_pend_reg    <= pgm_take;
      pgm_space_reg   <= i_pgm_space;
      pgm_ee_addr_reg <= i_pgm_addr[NV_DATA_W-1:0];
      o_pgm_valid     <= pgm_pend_reg;
      // Denial shown as a pulse, no data
      o_pgm_denied    <= i_pgm_rd && i_code_protect;
      if (pgm_pend_reg) begin
        o_pgm_data <= pgm_space_reg ? i_pf_word : {6'h0, ee_rd_pgm};
      end
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Data memory array
  // Low address byte picks the byte
  nvac_eeprom #(
    .DEPTH  (NV_EE_DEPTH),
    .ADDR_W (NV_EE_ADDR_W),
    .DATA_W (NV_DATA_W)
  ) u_eeprom (
    .i_clock     (i_clock),
    .i_wr_en     (ee_wr_en),
    .i_wr_addr   (ee_wr_addr),
    .i_wr_data   (ee_wr_data),
    .i_rd_addr_a (addr_lo_reg),
    .o_rd_data_a (ee_rd_core),
    .i_rd_addr_b (pgm_ee_addr_reg),
    .o_rd_data_b (ee_rd_pgm)
  );

endmodule

/* src/nvac_pkg.sv */
// Constants, register indices and state types for the memory access controller
package nvac_pkg;

  // ==========================================================
  // Register indices on the special function register port
  localparam logic [2:0] NV_IDX_CONTROL   = 3'h0;
  localparam logic [2:0] NV_IDX_UNLOCK    = 3'h1;
  localparam logic [2:0] NV_IDX_DATA_LOW  = 3'h2;
  localparam logic [2:0] NV_IDX_DATA_HIGH = 3'h3;
  localparam logic [2:0] NV_IDX_ADDR_LOW  = 3'h4;
  localparam logic [2:0] NV_IDX_ADDR_HIGH = 3'h5;

  // ==========================================================
  // Control register bit positions
  localparam int NV_BIT_SPACE   = 7;
  localparam int NV_BIT_ABORT   = 3;
  localparam int NV_BIT_PERMIT  = 2;
  localparam int NV_BIT_WSTROBE = 1;
  localparam int NV_BIT_RSTROBE = 0;

  // ==========================================================
  // Widths
  localparam int NV_DATA_W     = 8;
  localparam int NV_EE_ADDR_W  = 8;
  localparam int NV_EE_DEPTH   = 256;
  localparam int NV_DATA_HI_W  = 6;
  localparam int NV_ADDR_HI_W  = 5;
  localparam int NV_PF_WORD_W  = 14;
  localparam int NV_PF_ADDR_W  = 13;
  localparam int NV_PF_WORDS_4K = 4096;
  localparam int NV_PF_WORDS_8K = 8192;

  // ==========================================================
  // Values
  localparam logic [7:0] NV_UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] NV_UNLOCK_SECOND = 8'haa;
  localparam logic [7:0] NV_ERASED_BYTE   = 8'hff;
  localparam logic [7:0] NV_ZERO_BYTE     = 8'h00;

  // ==========================================================
  // Timing
  localparam int NV_CLK_PERIOD_NS = 10;
  localparam int NV_WRITE_TIME_US = 4;
  localparam int NV_WRITE_CYCLES  =
    (NV_WRITE_TIME_US * 1000 + NV_CLK_PERIOD_NS - 1) / NV_CLK_PERIOD_NS;

  // ==========================================================
  // State types
  typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} nvac_unlock_e;
  typedef enum logic       {WR_IDLE, WR_BUSY}                   nvac_write_e;

endpackage

/* src/nvac_eeprom.sv */
// Byte-wide data memory array with one write port and two read ports
`timescale 1ns/100ps
module nvac_eeprom
  import nvac_pkg::*;
#(
  parameter int DEPTH  = NV_EE_DEPTH,
  parameter int ADDR_W = NV_EE_ADDR_W,
  parameter int DATA_W = NV_DATA_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic [ADDR_W-1:0] i_rd_addr_a,
  output logic      [DATA_W-1:0] o_rd_data_a,
  input  wire logic [ADDR_W-1:0] i_rd_addr_b,
  output logic      [DATA_W-1:0] o_rd_data_b
);

  // ==========================================================
  // Storage
  // Nonvolatile contents: no reset, unknown until first written
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data_a = mem[i_rd_addr_a];
  assign o_rd_data_b = mem[i_rd_addr_b];

endmodule

/* sim/nvac_flash_model.sv */
// Program flash model answering the controller's word address
`timescale 1ns/100ps
module nvac_flash_model
  import nvac_pkg::*;
(
  input  wire logic [NV_PF_ADDR_W-1:0] i_addr,
  output logic      [NV_PF_WORD_W-1:0] o_word
);
  // ==========================================================
  // Read-only array
  // no write path
  // Each address gives a distinct word, so a wrong address shows at once
  assign o_word = {1'b1, i_addr} ^ 14'h12a5;
endmodule

/* sim/nvac_properties.sv */
// Port-level properties of the memory access controller
`timescale 1ns/100ps
module nvac_properties
  import nvac_pkg::*;
#(
  parameter int PF_WORDS = NV_PF_WORDS_8K
) (
  input wire logic                    i_clock,
  input wire logic                    i_rst,
  input wire logic [2:0]              i_sfr_idx,
  input wire logic                    i_sfr_rd,
  input wire logic [NV_DATA_W-1:0]    o_sfr_rdata,
  input wire logic                    i_done_flag_clear,
  input wire logic                    o_write_done_flag,
  input wire logic [NV_PF_ADDR_W-1:0] o_pf_addr,
  input wire logic                    i_code_protect,
  input wire logic                    i_pgm_rd,
  input wire logic                    i_pgm_space,
  input wire logic                    o_pgm_valid,
  input wire logic                    o_pgm_denied
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Register read-back
  a_unlock_reads_zero: assert property (i_sfr_rd && i_sfr_idx == NV_IDX_UNLOCK
    |=> o_sfr_rdata == 8'h00) else $error("unlock port read not zero");
  a_unused_reads_zero: assert property (i_sfr_rd && i_sfr_idx > 3'h5
    |=> o_sfr_rdata == 8'h00) else $error("unused index read not zero");
  a_data_high_width: assert property (i_sfr_rd && i_sfr_idx == NV_IDX_DATA_HIGH
    |=> o_sfr_rdata[7:6] == 2'h0) else $error("data high upper bits set");
  a_addr_high_width: assert property (i_sfr_rd && i_sfr_idx == NV_IDX_ADDR_HIGH
    |=> o_sfr_rdata[7:5] == 3'h0) else $error("address high upper bits set");
  a_control_unused: assert property (i_sfr_rd && i_sfr_idx == NV_IDX_CONTROL
    |=> o_sfr_rdata[6:4] == 3'h0) else $error("control unused bits set");
  a_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");
  // ==========================================================
  // Flags and flash address
  a_done_sticky: assert property (o_write_done_flag && !i_done_flag_clear
    |=> o_write_done_flag) else $error("done flag dropped without clear");
  a_pf_addr_range: assert property (o_pf_addr < PF_WORDS)
    else $error("flash address beyond array");
  // ==========================================================
  // Programmer port
  a_pgm_answered: assert property (i_pgm_rd && !i_code_protect && !i_pgm_space
    |-> ##[1:2] o_pgm_valid) else $error("programmer read not answered");
  a_pgm_blocked: assert property (i_pgm_rd && i_code_protect
    |-> ##[1:2] o_pgm_denied) else $error("protected read not denied");
endmodule
bind nvac_top nvac_properties #(.PF_WORDS(PF_WORDS)) u_nvac_properties (.i_clock, .i_rst,
  .i_sfr_idx, .i_sfr_rd, .o_sfr_rdata, .i_done_flag_clear, .o_write_done_flag, .o_pf_addr,
  .i_code_protect, .i_pgm_rd, .i_pgm_space, .o_pgm_valid, .o_pgm_denied);

/* sim/nv_memory_access_control_test.sv */
// Self-checking bench for the memory access controller
`timescale 1ns/100ps
module nv_memory_access_control_test;
  import nvac_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, por = 1'b1, ext = 1'b0, wdg = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, clr = 1'b0, cp = 1'b0, prd = 1'b0, psp = 1'b0;
  logic [2:0]  idx = 3'h0;
  logic [7:0]  wd = 8'h00, rdata;
  logic [12:0] paddr = 13'h0000, pfa;
  logic [13:0] pfw, pdata;
  logic        done, pvalid, pden;
  int          errors = 0, checked = 0;

  nvac_top #(.PF_WORDS(NV_PF_WORDS_4K), .WRITE_CYCLES(40)) u_nvac_top (.i_clock(clk),
    .i_rst(rst), .i_rst_power_on(por), .i_rst_external(ext), .i_rst_watchdog(wdg),
    .i_sfr_idx(idx), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata),
    .i_done_flag_clear(clr), .o_write_done_flag(done), .o_pf_addr(pfa), .i_pf_word(pfw),
    .i_code_protect(cp), .i_pgm_rd(prd), .i_pgm_space(psp), .i_pgm_addr(paddr),
    .o_pgm_data(pdata), .o_pgm_valid(pvalid), .o_pgm_denied(pden));
  nvac_flash_model u_nvac_flash_model (.i_addr(pfa), .o_word(pfw));

  always #5 clk = ~clk;

  // ==========================================================
  // Bus tasks
  function automatic logic [13:0] pf(input logic [12:0] a);
    return {1'b1, a} ^ 14'h12a5;
  endfunction
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe dropped for a cycle so back-to-back calls never assign it twice
  task automatic sw(input logic [2:0] i, input logic [7:0] d);
    idx = i;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic sr(input logic [2:0] i, input logic [7:0] e);
    idx = i;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({6'h00, rdata}, {6'h00, e});
    @(negedge clk);
  endtask
  task automatic unlock;
    sw(NV_IDX_UNLOCK, NV_UNLOCK_FIRST);
    sw(NV_IDX_UNLOCK, NV_UNLOCK_SECOND);
  endtask
  task automatic pg(input logic s, input logic [12:0] a, input logic [13:0] e, input logic dn);
    int nv, nd;
    nv = 0;
    nd = 0;
    psp = s;
    paddr = a;
    prd = 1'b1;
    @(negedge clk);
    prd = 1'b0;
    repeat (3) begin
      if (pvalid === 1'b1) nv++;
      if (pden === 1'b1) nd++;
      @(negedge clk);
    end
    chk(14'(nv), {13'h0, !dn});
    chk(14'(nd), {13'h0, dn});
    if (!dn) chk(pdata, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 8; i++) sr(3'(i), 8'h00);
    sw(NV_IDX_DATA_HIGH, 8'hff);
    sr(NV_IDX_DATA_HIGH, 8'h3f);
    sw(3'h6, 8'hff);
    sr(3'h6, 8'h00);
  endtask
  task automatic t_write;
    int n;
    sw(NV_IDX_ADDR_LOW, 8'ha5);
    sw(NV_IDX_DATA_LOW, 8'h3c);
    sw(NV_IDX_CONTROL, 8'h04);
    unlock();
    sw(NV_IDX_CONTROL, 8'h06);
    sw(NV_IDX_DATA_LOW, 8'h00);
    sw(NV_IDX_CONTROL, 8'h00);
    sr(NV_IDX_CONTROL, 8'h02);
    chk(done, 1'b0);
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(done, 1'b1);
    sr(NV_IDX_CONTROL, 8'h00);
    sw(NV_IDX_CONTROL, 8'h01);
    sr(NV_IDX_DATA_LOW, 8'h3c);
    chk(done, 1'b1);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk(done, 1'b0);
  endtask
  task automatic t_refuse;
    sw(NV_IDX_CONTROL, 8'h00);
    unlock();
    sw(NV_IDX_CONTROL, 8'h02);
    sr(NV_IDX_CONTROL, 8'h00);
    sw(NV_IDX_CONTROL, 8'h04);
    sw(NV_IDX_UNLOCK, NV_UNLOCK_FIRST);
    sw(NV_IDX_DATA_LOW, 8'h77);
    sw(NV_IDX_UNLOCK, NV_UNLOCK_SECOND);
    sw(NV_IDX_CONTROL, 8'h06);
    sr(NV_IDX_CONTROL, 8'h04);
    sw(NV_IDX_CONTROL, 8'h84);
    unlock();
    sw(NV_IDX_CONTROL, 8'h86);
    sr(NV_IDX_CONTROL, 8'h84);
    repeat (50) @(negedge clk);
    chk(done, 1'b0);
    sw(NV_IDX_CONTROL, 8'h01);
    sr(NV_IDX_DATA_LOW, 8'h3c);
  endtask
  task automatic t_flash;
    logic [13:0] w;
    w = pf(13'h0fff);
    sw(NV_IDX_ADDR_HIGH, 8'hff);
    sw(NV_IDX_ADDR_LOW, 8'hff);
    sr(NV_IDX_ADDR_HIGH, 8'h1f);
    sw(NV_IDX_CONTROL, 8'h81);
    chk({1'b0, pfa}, 14'h0fff);
    sr(NV_IDX_DATA_LOW, w[7:0]);
    sr(NV_IDX_DATA_HIGH, {2'b00, w[13:8]});
  endtask
  task automatic t_pgm;
    pg(1'b0, 13'h00a5, 14'h003c, 1'b0);
    pg(1'b1, 13'h0123, pf(13'h0123), 1'b0);
    cp = 1'b1;
    pg(1'b0, 13'h00a5, 14'h0000, 1'b1);
    sw(NV_IDX_ADDR_LOW, 8'ha5);
    sw(NV_IDX_CONTROL, 8'h01);
    sr(NV_IDX_DATA_LOW, 8'h3c);
    cp = 1'b0;
  endtask
  task automatic t_abort;
    for (int c = 0; c < 2; c++) begin
      sw(NV_IDX_ADDR_LOW, 8'h5a);
      sw(NV_IDX_DATA_LOW, 8'h11);
      sw(NV_IDX_CONTROL, 8'h04);
      unlock();
      sw(NV_IDX_CONTROL, 8'h06);
      rst = 1'b1;
      ext = (c == 0);
      wdg = (c == 1);
      @(negedge clk);
      rst = 1'b0;
      ext = 1'b0;
      wdg = 1'b0;
      sr(NV_IDX_CONTROL, 8'h08);
      sr(NV_IDX_DATA_LOW, 8'h00);
      sr(NV_IDX_ADDR_LOW, 8'h00);
      chk(done, 1'b0);
      sw(NV_IDX_ADDR_LOW, 8'h5a);
      sw(NV_IDX_CONTROL, 8'h01);
      sr(NV_IDX_DATA_LOW, NV_ERASED_BYTE);
    end
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    por = 1'b0;
    t_regs();
    $display("register test done");
    t_write();
    $display("write test done");
    t_refuse();
    $display("refusal test done");
    t_flash();
    $display("flash test done");
    t_pgm();
    $display("programmer test done");
    t_abort();
    $display("abort test done");
    results();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule
